// *** verilog/strobe_pkg.sv ***
// package: command codes, radio states, carrier structs and timing for the strobe handler
package strobe_pkg;

  // command byte encodings (plain defaults; the decoder only needs distinct codes)
  localparam logic [7:0] CMD_NOP                = 8'h00;
  localparam logic [7:0] CMD_TX_SYNTH_CALIBRATE = 8'h41;
  localparam logic [7:0] CMD_RECEIVE_ON         = 8'h42;
  localparam logic [7:0] CMD_TRANSMIT_ON        = 8'h43;
  localparam logic [7:0] CMD_TRANSMIT_IF_CLEAR  = 8'h44;
  localparam logic [7:0] CMD_RADIO_OFF          = 8'h45;
  localparam logic [7:0] CMD_OSCILLATOR_OFF     = 8'h46;
  localparam logic [7:0] CMD_FLUSH_RECEIVE      = 8'h47;
  localparam logic [7:0] CMD_FLUSH_TRANSMIT     = 8'h48;

  // synthesizer calibration time
  localparam int CAL_TIME_NS  = 200;
  localparam int CLK_PERIOD_NS = 10;
  localparam int CAL_CYCLES   = (CAL_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [4:0] CAL_CNT_INIT = 5'(CAL_CYCLES);

  // reset values
  localparam logic RST_OSC_ON   = 1'b1;
  localparam logic RST_CCA_BIT  = 1'b0;

  typedef enum logic [2:0] {
    RADIO_IDLE,
    RADIO_CAL,
    RADIO_SYNTH_WAIT,
    RADIO_RX,
    RADIO_TX
  } radio_state_t;

  // command from the spi front end: one-cycle strobe with its byte
  typedef struct packed {
    logic       valid;
    logic       truncated;
    logic [7:0] code;
  } cmd_req_t;

  // one-cycle exception pulses
  typedef struct packed {
    logic frame_aborted;
    logic misuse;
    logic bad_operand;
  } exc_t;

  // one-cycle action pulses to the datapath
  typedef struct packed {
    logic flush_receive;
    logic flush_transmit;
    logic demod_reset;
  } action_t;

endpackage

// *** verilog/radio_command_strobe_handler.sv ***
// module: decodes radio command strobes and sequences the radio state
// Contract
// RQ1 - calibrate command parks radio in synth wait
// RQ2 - aborting commands during reception raise frame-aborted
// RQ3 - transmit-on calibrates first when not yet calibrated
// RQ4 - clear-gated transmit only on free channel
// RQ5 - clear-gated transmit captures cca into status
// RQ6 - radio-off disables receiver, transmitter, synthesizer
// RQ7 - radio-off when all off: misuse, no change
// RQ8 - oscillator-off switches crystal oscillator off
// RQ9 - oscillator-off with radio busy raises misuse
// RQ10 - flush receive empties fifo, resets demodulator
// RQ11 - receive-on enables rx; flush transmit silent
// RQ12 - unknown or truncated command: bad operand
`timescale 1ns/1ns
`default_nettype none
module radio_command_strobe_handler (
  input  wire logic                 mclk,
  input  wire logic                 reset_n,
  input  wire strobe_pkg::cmd_req_t cmd_in,
  input  wire logic                 frame_receiving,
  input  wire logic                 cca_pin,
  output var  strobe_pkg::exc_t     exc_out,
  output var  strobe_pkg::action_t  action_out,
  output var  strobe_pkg::radio_state_t radio_state,
  output logic                      crystal_oscillator_on,
  output logic                      cca_status,
  output logic                      rx_enabled,
  output logic                      tx_enabled,
  output logic                      synth_enabled
);
  import strobe_pkg::*;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  // cca comes from the analog side, so it is resynchronised before use
  logic cca_s1_q, cca_s2_q;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cca_s1_q <= 1'b0;
      cca_s2_q <= 1'b0;
    end else begin
      cca_s1_q <= cca_pin;
      cca_s2_q <= cca_s1_q;
    end
  end

  // ----------------------------------------------------------------
  // command decode
  // ----------------------------------------------------------------
  radio_state_t state_q, state_d;
  logic         calibrated_q, calibrated_d;
  logic         tx_after_cal_q, tx_after_cal_d;
  logic [4:0]   cal_cnt_q, cal_cnt_d;
  logic         osc_q, osc_d;
  logic         cca_q, cca_d;
  exc_t         exc_d;
  action_t      act_d;

  wire ok        = cmd_in.valid && !cmd_in.truncated;
  wire is_cal    = ok && cmd_in.code == CMD_TX_SYNTH_CALIBRATE;
  wire is_rxon   = ok && cmd_in.code == CMD_RECEIVE_ON;
  wire is_txon   = ok && cmd_in.code == CMD_TRANSMIT_ON;
  wire is_txcca  = ok && cmd_in.code == CMD_TRANSMIT_IF_CLEAR;
  wire is_rfoff  = ok && cmd_in.code == CMD_RADIO_OFF;
  wire is_oscoff = ok && cmd_in.code == CMD_OSCILLATOR_OFF;
  wire is_flrx   = ok && cmd_in.code == CMD_FLUSH_RECEIVE;
  wire is_fltx   = ok && cmd_in.code == CMD_FLUSH_TRANSMIT;
  wire is_nop    = ok && cmd_in.code == CMD_NOP;
  wire known     = is_cal | is_rxon | is_txon | is_txcca | is_rfoff | is_oscoff
                 | is_flrx | is_fltx | is_nop;
  // frame-aborting commands; clear-gated transmit and tx flush are not in the set
  wire aborts    = is_cal | is_rxon | is_txon | is_rfoff | is_oscoff | is_flrx; // RQ2
  wire radio_idle = (state_q == RADIO_IDLE);
  wire cca_clear  = cca_s2_q;

  // ----------------------------------------------------------------
  // next-state logic
  // ----------------------------------------------------------------
  // calibration takes a fixed count; a pending transmit follows it
  always_comb begin
    state_d        = state_q;
    calibrated_d   = calibrated_q;
    tx_after_cal_d = tx_after_cal_q;
    cal_cnt_d      = cal_cnt_q;
    osc_d          = osc_q;
    cca_d          = cca_q;
    exc_d          = '0;
    act_d          = '0;
    if (state_q == RADIO_CAL) begin
      if (cal_cnt_q == 5'h01) begin
        calibrated_d = 1'b1;
        state_d      = tx_after_cal_q ? RADIO_TX : RADIO_SYNTH_WAIT;
      end
      cal_cnt_d = cal_cnt_q - 5'h01;
    end
    exc_d.frame_aborted = aborts && frame_receiving; // RQ2
    exc_d.bad_operand   = cmd_in.valid && (cmd_in.truncated || !known); // RQ12
    if (is_cal) begin
      state_d        = RADIO_CAL; // RQ1
      tx_after_cal_d = 1'b0;
      cal_cnt_d      = CAL_CNT_INIT;
    end
    if (is_rxon) begin
      state_d = RADIO_RX; // RQ11
    end
    if (is_txon) begin
      if (calibrated_q) begin
        state_d = RADIO_TX; // RQ3
      end else begin
        state_d        = RADIO_CAL; // RQ3
        tx_after_cal_d = 1'b1;
        cal_cnt_d      = CAL_CNT_INIT;
      end
    end
    if (is_txcca) begin
      cca_d = cca_clear; // RQ5
      if (cca_clear) begin
        state_d        = RADIO_CAL; // RQ4
        tx_after_cal_d = 1'b1;
        cal_cnt_d      = CAL_CNT_INIT;
      end
    end
    if (is_rfoff) begin
      if (radio_idle) begin
        exc_d.misuse = 1'b1; // RQ7
      end else begin
        state_d      = RADIO_IDLE; // RQ6
        calibrated_d = 1'b0;
      end
    end
    if (is_oscoff) begin
      osc_d = 1'b0; // RQ8
      if (!radio_idle) begin
        exc_d.misuse = 1'b1; // RQ9
      end
    end
    if (is_flrx) begin
      act_d.flush_receive = 1'b1; // RQ10
      act_d.demod_reset   = 1'b1; // RQ10
    end
    if (is_fltx) begin
      act_d.flush_transmit = 1'b1; // RQ11
    end
  end

  // ----------------------------------------------------------------
  // state registers
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      state_q        <= RADIO_IDLE;
      calibrated_q   <= 1'b0;
      tx_after_cal_q <= 1'b0;
      cal_cnt_q      <= 5'h00;
      osc_q          <= RST_OSC_ON;
      cca_q          <= RST_CCA_BIT;
      exc_out        <= '0;
      action_out     <= '0;
    end else begin
      state_q        <= state_d;
      calibrated_q   <= calibrated_d;
      tx_after_cal_q <= tx_after_cal_d;
      cal_cnt_q      <= cal_cnt_d;
      osc_q          <= osc_d;
      cca_q          <= cca_d;
      exc_out        <= exc_d;
      action_out     <= act_d;
    end
  end

  // state, oscillator and cca outputs straight from flip-flops; rx, tx and synth enables decoded from the state
  assign radio_state           = state_q;
  assign crystal_oscillator_on = osc_q;
  assign cca_status            = cca_q;
  assign rx_enabled            = (state_q == RADIO_RX);
  assign tx_enabled            = (state_q == RADIO_TX);
  assign synth_enabled         = !radio_idle;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  property p_cal_enters;
    @(posedge mclk) disable iff (!reset_n) is_cal |=> state_q == RADIO_CAL;
  endproperty
  a_cal_enters: assert property (p_cal_enters) else $error("calibrate not entered"); // RQ1

  property p_abort;
    @(posedge mclk) disable iff (!reset_n)
      (aborts && frame_receiving) |=> exc_out.frame_aborted;
  endproperty
  a_abort: assert property (p_abort) else $error("frame abort not raised"); // RQ2

  property p_txon_uncal;
    @(posedge mclk) disable iff (!reset_n)
      (is_txon && !calibrated_q && state_q != RADIO_CAL) |=> state_q == RADIO_CAL;
  endproperty
  a_txon_uncal: assert property (p_txon_uncal) else $error("tx without calibration"); // RQ3

  property p_txcca_busy;
    @(posedge mclk) disable iff (!reset_n)
      (is_txcca && !cca_clear && state_q != RADIO_CAL) |=> $stable(state_q);
  endproperty
  a_txcca_busy: assert property (p_txcca_busy) else $error("busy channel changed state"); // RQ4

  property p_cca_capture;
    @(posedge mclk) disable iff (!reset_n) is_txcca |=> cca_status == $past(cca_s2_q);
  endproperty
  a_cca_capture: assert property (p_cca_capture) else $error("cca not captured"); // RQ5

  property p_rfoff;
    @(posedge mclk) disable iff (!reset_n)
      (is_rfoff && !radio_idle) |=> !rx_enabled && !tx_enabled && !synth_enabled;
  endproperty
  a_rfoff: assert property (p_rfoff) else $error("radio off failed"); // RQ6

  property p_rfoff_misuse;
    @(posedge mclk) disable iff (!reset_n)
      (is_rfoff && radio_idle) |=> exc_out.misuse && radio_state == RADIO_IDLE;
  endproperty
  a_rfoff_misuse: assert property (p_rfoff_misuse) else $error("radio off misuse"); // RQ7

  property p_oscoff;
    @(posedge mclk) disable iff (!reset_n)
      is_oscoff |=> !crystal_oscillator_on && (exc_out.misuse == !$past(radio_idle));
  endproperty
  a_oscoff: assert property (p_oscoff) else $error("oscillator off wrong"); // RQ9

  property p_flush_rx;
    @(posedge mclk) disable iff (!reset_n)
      is_flrx |=> action_out.flush_receive && action_out.demod_reset;
  endproperty
  a_flush_rx: assert property (p_flush_rx) else $error("rx flush missing"); // RQ10

  property p_bad_op;
    @(posedge mclk) disable iff (!reset_n)
      (cmd_in.valid && !known) |=> exc_out.bad_operand;
  endproperty
  a_bad_op: assert property (p_bad_op) else $error("bad operand missing"); // RQ12

  c_tx_via_cal: cover property (@(posedge mclk) disable iff (!reset_n)
    state_q == RADIO_CAL ##1 state_q == RADIO_TX);
  c_txcca_busy: cover property (@(posedge mclk) disable iff (!reset_n) is_txcca && !cca_clear);
  c_abort: cover property (@(posedge mclk) disable iff (!reset_n) exc_out.frame_aborted);

endmodule // radio_command_strobe_handler
`default_nettype wire

// *** tb/host_model.sv ***
// host side model: issues single command bytes toward the strobe handler
`timescale 1ns/1ns
`default_nettype none
module host_model
  import strobe_pkg::*;
(
  input  wire logic               mclk,
  output var  strobe_pkg::cmd_req_t cmd
);
  initial cmd = '0;
  // one-cycle strobe; the code is inverted afterwards so a stale byte never looks valid
  task automatic send(input logic [7:0] code, input logic trunc);
    @(posedge mclk);
    cmd <= '{valid: 1'b1, truncated: trunc, code: code};
    @(posedge mclk);
    cmd <= '{valid: 1'b0, truncated: 1'b0, code: ~code};
  endtask
endmodule // host_model
`default_nettype wire

// *** tb/radio_command_strobe_handler_tb.sv ***
// testbench: command strobes, exceptions, radio state walk
`timescale 1ns/1ns
`default_nettype none
module radio_command_strobe_handler_tb;
  import strobe_pkg::*;
  logic         mclk, reset_n, frame_receiving, cca_pin;
  cmd_req_t     cmd_in;
  exc_t         exc_out;
  action_t      action_out;
  radio_state_t radio_state;
  logic         osc_on, cca_status, rx_en, tx_en, syn_en;
  int           n_errors = 0;
  int           compares = 0;

  host_model u_host_model (.mclk(mclk), .cmd(cmd_in));
  radio_command_strobe_handler u_radio_command_strobe_handler (
    .mclk(mclk), .reset_n(reset_n), .cmd_in(cmd_in),
    .frame_receiving(frame_receiving), .cca_pin(cca_pin),
    .exc_out(exc_out), .action_out(action_out), .radio_state(radio_state),
    .crystal_oscillator_on(osc_on), .cca_status(cca_status),
    .rx_enabled(rx_en), .tx_enabled(tx_en), .synth_enabled(syn_en));

  // -----------------------------------------
  // helpers
  // -----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  // answer lands at the taking edge; look 1 ns later while the pulses stand
  task automatic do_cmd(input logic [7:0] c, input logic t, input logic [2:0] ee,
                        input logic [2:0] ea, input radio_state_t es);
    u_host_model.send(c, t);
    #1;
    chk(8'(exc_out), 8'(ee));
    chk(8'(action_out), 8'(ea));
    chk(8'(radio_state), 8'(es));
  endtask
  // bounded wait; leaving calibration early is as wrong as never leaving it
  task automatic wait_state(input radio_state_t es);
    int n;
    // step off the edge so the first look sees settled outputs
    #1;
    n = 0;
    while (radio_state !== es && n < CAL_CYCLES + 5) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(8'(radio_state), 8'(es));
    chk(8'(n > CAL_CYCLES - 3), 8'h01);
    if (radio_state !== es) end_of_test();
  endtask

  // -----------------------------------------
  // scenarios
  // -----------------------------------------
  task automatic sc_idle_errors();
    chk(8'({osc_on, cca_status}), 8'h02);
    do_cmd(CMD_RADIO_OFF, 1'b0, 3'h2, 3'h0, RADIO_IDLE);
    do_cmd(8'h99, 1'b0, 3'h1, 3'h0, RADIO_IDLE);
    do_cmd(CMD_RECEIVE_ON, 1'b1, 3'h1, 3'h0, RADIO_IDLE);
  endtask
  task automatic sc_receive();
    do_cmd(CMD_RECEIVE_ON, 1'b0, 3'h0, 3'h0, RADIO_RX);
    chk(8'(rx_en), 8'h01);
    @(posedge mclk);
    frame_receiving <= 1'b1;
    do_cmd(CMD_FLUSH_RECEIVE, 1'b0, 3'h4, 3'h5, RADIO_RX);
    do_cmd(CMD_FLUSH_TRANSMIT, 1'b0, 3'h0, 3'h2, RADIO_RX);
    do_cmd(CMD_TX_SYNTH_CALIBRATE, 1'b0, 3'h4, 3'h0, RADIO_CAL);
    @(posedge mclk);
    frame_receiving <= 1'b0;
    wait_state(RADIO_SYNTH_WAIT);
    chk(8'({rx_en, tx_en, syn_en}), 8'h01);
  endtask
  task automatic sc_transmit();
    do_cmd(CMD_TRANSMIT_ON, 1'b0, 3'h0, 3'h0, RADIO_TX);
    do_cmd(CMD_OSCILLATOR_OFF, 1'b0, 3'h2, 3'h0, RADIO_TX);
    chk(8'(osc_on), 8'h00);
    do_cmd(CMD_RADIO_OFF, 1'b0, 3'h0, 3'h0, RADIO_IDLE);
    chk(8'({rx_en, tx_en, syn_en}), 8'h00);
    do_cmd(CMD_TRANSMIT_ON, 1'b0, 3'h0, 3'h0, RADIO_CAL);
    wait_state(RADIO_TX);
    chk(8'(tx_en), 8'h01);
  endtask
  task automatic sc_clear_gated();
    do_cmd(CMD_RADIO_OFF, 1'b0, 3'h0, 3'h0, RADIO_IDLE);
    @(posedge mclk);
    cca_pin <= 1'b1;
    repeat (3) @(posedge mclk);
    do_cmd(CMD_TRANSMIT_IF_CLEAR, 1'b0, 3'h0, 3'h0, RADIO_CAL);
    chk(8'(cca_status), 8'h01);
    wait_state(RADIO_TX);
    @(posedge mclk);
    cca_pin <= 1'b0;
    repeat (3) @(posedge mclk);
    // busy channel while transmitting: state stays, status drops to busy
    do_cmd(CMD_TRANSMIT_IF_CLEAR, 1'b0, 3'h0, 3'h0, RADIO_TX);
    chk(8'(cca_status), 8'h00);
    do_cmd(CMD_RADIO_OFF, 1'b0, 3'h0, 3'h0, RADIO_IDLE);
    do_cmd(CMD_TRANSMIT_IF_CLEAR, 1'b0, 3'h0, 3'h0, RADIO_IDLE);
    chk(8'(cca_status), 8'h00);
  endtask
  // second reset in mid-run: the oscillator comes back on and the radio idles
  task automatic sc_reset_again();
    do_cmd(CMD_RECEIVE_ON, 1'b0, 3'h0, 3'h0, RADIO_RX);
    @(posedge mclk);
    reset_n <= 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    #1;
    chk(8'({osc_on, cca_status}), 8'h02);
    chk(8'(radio_state), 8'(RADIO_IDLE));
    do_cmd(CMD_NOP, 1'b0, 3'h0, 3'h0, RADIO_IDLE);
  endtask

  // -----------------------------------------
  // clock, reset and main sequence
  // -----------------------------------------
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end
  initial begin
    reset_n = 1'b0;
    frame_receiving = 1'b0;
    cca_pin = 1'b0;
    repeat (5) @(posedge mclk);
    reset_n <= 1'b1;
    sc_idle_errors();
    sc_receive();
    sc_transmit();
    sc_clear_gated();
    sc_reset_again();
    end_of_test();
  end
endmodule // radio_command_strobe_handler_tb
`default_nettype wire
